// [aes_core.sv]
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - blocks of 128 bits, up to two held unread in the output buffer
// - key or IV load aborts processing
// - key kept until next key load
// - reset clears key and IV
// - start raises input request trigger, in stream modes only after the cipher
// - interrupt after each finished block
// - stream modes run four 32-bit parts
// - ECB, CBC, CFB, OFB, CTR, CBC-MAC
// - key and IV are 128 bits
// - CBC-MAC blocks, last in CBC gives MAC
// - separate input and output requests
module aes_core
  import aes_pkg::*;
#(
  parameter int FIFO_D = AES_FIFO_D
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  ctrl_wr,
  input  wire aes_ctrl_s             ctrl_wdata,
  output aes_stat_s                  crypto_ctrl_status,
  input  wire logic [AES_WORD_W-1:0] crypto_input_port,
  input  wire logic                  in_valid,
  output logic                       input_request_trigger,
  output logic [AES_WORD_W-1:0]      crypto_output_port,
  input  wire logic                  out_ready,
  output logic                       output_request_trigger,
  output logic                       block_done_irq
);

  // ==========================================================
  // field arithmetic
  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] p, x;
    p = '0;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? AES_POLY : 8'h00);
    end
    return p;
  endfunction : gmul

  function automatic logic [7:0] rl(input logic [7:0] x, input int n);
    logic [15:0] d;
    d = {x, x} << n;
    return d[15:8];
  endfunction : rl

  // x^254 is the inverse, and maps zero to zero as needed
  function automatic logic [7:0] ginv(input logic [7:0] x);
    logic [7:0] r, p;
    r = 8'h01;
    p = x;
    for (int i = 1; i < 8; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    return r;
  endfunction : ginv

  function automatic logic [7:0] sb(input logic [7:0] x);
    logic [7:0] y;
    y = ginv(x);
    return y ^ rl(y, 1) ^ rl(y, 2) ^ rl(y, 3) ^ rl(y, 4) ^ SBOX_C;
  endfunction : sb

  function automatic logic [7:0] isb(input logic [7:0] x);
    return ginv(rl(x, 1) ^ rl(x, 3) ^ rl(x, 6) ^ ISBOX_C);
  endfunction : isb

  // ==========================================================
  // round primitives, byte 0 in the top bits
  function automatic logic [127:0] mix(input logic [127:0] s,
                                       input logic [31:0] cf);
    logic [127:0] m;
    logic [7:0]   acc;
    m = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        acc = '0;
        for (int j = 0; j < 4; j++) begin
          acc = acc ^ gmul(cf[(3 - ((j - r + 4) % 4)) * 8 +: 8],
                           s[(15 - (4 * c + j)) * 8 +: 8]);
        end
        m[(15 - (4 * c + r)) * 8 +: 8] = acc;
      end
    end
    return m;
  endfunction : mix

  function automatic logic [127:0] enc_round(input logic [127:0] s,
                                             input logic [127:0] k,
                                             input logic last);
    logic [127:0] t;
    t = '0;
    for (int i = 0; i < 16; i++) begin
      t[(15 - i) * 8 +: 8] =
        sb(s[(15 - (4 * (((i / 4) + (i % 4)) % 4) + i % 4)) * 8 +: 8]);
    end
    return (last ? t : mix(t, MIX_ENC)) ^ k;
  endfunction : enc_round

  function automatic logic [127:0] dec_round(input logic [127:0] s,
                                             input logic [127:0] k,
                                             input logic last);
    logic [127:0] t;
    t = '0;
    for (int i = 0; i < 16; i++) begin
      t[(15 - (4 * (((i / 4) + (i % 4)) % 4) + i % 4)) * 8 +: 8] =
        isb(s[(15 - i) * 8 +: 8]);
    end
    t = t ^ k;
    return last ? t : mix(t, MIX_DEC);
  endfunction : dec_round

  function automatic logic [31:0] subrot(input logic [31:0] w,
                                         input logic [7:0] rc);
    return {sb(w[23:16]) ^ rc, sb(w[15:8]), sb(w[7:0]), sb(w[31:24])};
  endfunction : subrot

  function automatic logic [127:0] kexp(input logic [127:0] k,
                                        input logic [7:0] rc);
    logic [31:0] n0, n1, n2;
    n0 = k[127:96] ^ subrot(k[31:0], rc);
    n1 = k[95:64] ^ n0;
    n2 = k[63:32] ^ n1;
    return {n0, n1, n2, k[31:0] ^ n2};
  endfunction : kexp

  function automatic logic [127:0] kinv(input logic [127:0] k,
                                        input logic [7:0] rc);
    logic [31:0] n3;
    n3 = k[31:0] ^ k[63:32];
    return {k[127:96] ^ subrot(n3, rc), k[95:64] ^ k[127:96],
            k[63:32] ^ k[95:64], n3};
  endfunction : kinv

  function automatic logic is_stream(input logic [2:0] m);
    return m == MODE_CFB || m == MODE_OFB || m == MODE_CTR;
  endfunction : is_stream

  // ==========================================================
  // state
  aes_state_e   state_reg, state_next;
  aes_cmd_e     cmd_reg, cmd_next;
  logic [2:0]   mode_reg, mode_next;
  logic [127:0] key_reg, key_next, dkey_reg, dkey_next;
  logic [127:0] iv_reg, iv_next, buf_reg, buf_next;
  logic [127:0] st_reg, st_next, rk_reg, rk_next;
  logic [7:0]   rc_reg, rc_next;
  logic [3:0]   rnd_reg, rnd_next;
  logic [1:0]   wcnt_reg, wcnt_next;
  logic         irq_reg, irq_next;
  logic [127:0] nb, sn, kn, kp;
  logic [31:0]  ks, ow;
  logic         dec, last;
  logic         f_in_valid, f_in_ready;
  logic [31:0]  f_in_data;

  always_comb begin
    state_next = state_reg;
    cmd_next   = cmd_reg;
    mode_next  = mode_reg;
    key_next   = key_reg;
    dkey_next  = dkey_reg;
    iv_next    = iv_reg;
    buf_next   = buf_reg;
    st_next    = st_reg;
    rk_next    = rk_reg;
    rc_next    = rc_reg;
    rnd_next   = rnd_reg;
    wcnt_next  = wcnt_reg;
    irq_next   = 1'b0;
    input_request_trigger = 1'b0;
    f_in_valid = 1'b0;
    f_in_data  = buf_reg[(3 - wcnt_reg) * 32 +: 32];
    nb   = {buf_reg[95:0], crypto_input_port};
    kn   = kexp(rk_reg, rc_reg);
    kp   = kinv(rk_reg, rc_reg);
    dec  = cmd_reg == CMD_DEC && !is_stream(mode_reg)
           && mode_reg != MODE_CBCMAC;
    last = rnd_reg == AES_LAST_R;
    sn   = dec ? dec_round(st_reg, kp, last)
               : enc_round(st_reg, kn, last);
    ks   = buf_reg[(3 - wcnt_reg) * 32 +: 32];
    ow   = crypto_input_port ^ ks;
    case (state_reg)
      S_COLLECT: begin
        input_request_trigger = 1'b1;
        if (in_valid) begin
          buf_next  = nb;
          wcnt_next = wcnt_reg + 1'b1;
          if (wcnt_reg == AES_LAST_W) begin
            rnd_next   = '0;
            state_next = S_CIPHER;
            case (cmd_reg)
              CMD_KEY: begin
                key_next   = nb;
                rk_next    = nb;
                rc_next    = RCON_FIRST;
                state_next = S_KEYEXP;
              end
              CMD_IV: begin
                iv_next    = nb;
                irq_next   = 1'b1;
                state_next = S_IDLE;
              end
              default: begin
                if (dec) begin
                  st_next = nb ^ dkey_reg;
                  rk_next = dkey_reg;
                  rc_next = RCON_LAST;
                end else begin
                  st_next = nb ^ key_reg ^ ((mode_reg == MODE_ECB)
                            ? 128'h0 : iv_reg);
                  rk_next = key_reg;
                  rc_next = RCON_FIRST;
                end
              end
            endcase
          end
        end
      end
      S_KEYEXP: begin
        // last round key kept so decryption can run the schedule back
        rk_next  = kn;
        rc_next  = {rc_reg[6:0], 1'b0} ^ (rc_reg[7] ? AES_POLY : 8'h00);
        rnd_next = rnd_reg + 1'b1;
        if (last) begin
          dkey_next  = kn;
          irq_next   = 1'b1;
          state_next = S_IDLE;
        end
      end
      S_CIPHER: begin
        st_next  = sn;
        rk_next  = dec ? kp : kn;
        rc_next  = dec ? ((rc_reg == AES_POLY) ? RCON_TOP : rc_reg >> 1)
                       : {rc_reg[6:0], 1'b0}
                         ^ (rc_reg[7] ? AES_POLY : 8'h00);
        rnd_next = rnd_reg + 1'b1;
        if (last) begin
          wcnt_next  = '0;
          buf_next   = sn;
          state_next = S_EMIT;
          if (is_stream(mode_reg)) begin
            state_next = S_PART;
          end else if (mode_reg == MODE_CBCMAC) begin
            iv_next    = sn;
            irq_next   = 1'b1;
            state_next = S_IDLE;
          end else if (mode_reg == MODE_CBC) begin
            iv_next = dec ? buf_reg : sn;
            if (dec) buf_next = sn ^ iv_reg;
          end
        end
      end
      S_PART: begin
        input_request_trigger = f_in_ready;
        if (in_valid && f_in_ready) begin
          f_in_valid = 1'b1;
          f_in_data  = ow;
          wcnt_next  = wcnt_reg + 1'b1;
          if (mode_reg == MODE_CFB) begin
            iv_next[(3 - wcnt_reg) * 32 +: 32] =
              (cmd_reg == CMD_DEC) ? crypto_input_port : ow;
          end else if (mode_reg == MODE_OFB) begin
            iv_next[(3 - wcnt_reg) * 32 +: 32] = ks;
          end
          if (wcnt_reg == AES_LAST_W) begin
            // counter advances only in its low word
            if (mode_reg == MODE_CTR) iv_next[31:0] = iv_reg[31:0] + 1'b1;
            irq_next   = 1'b1;
            state_next = S_IDLE;
          end
        end
      end
      S_EMIT: begin
        f_in_valid = 1'b1;
        if (f_in_ready) begin
          wcnt_next = wcnt_reg + 1'b1;
          if (wcnt_reg == AES_LAST_W) begin
            irq_next   = 1'b1;
            state_next = S_IDLE;
          end
        end
      end
      default: ;
    endcase
    if (ctrl_wr) begin
      mode_next = ctrl_wdata.mode;
      if (ctrl_wdata.start) begin
        if (ctrl_wdata.cmd == CMD_KEY || ctrl_wdata.cmd == CMD_IV) begin
          cmd_next   = ctrl_wdata.cmd;
          wcnt_next  = '0;
          state_next = S_COLLECT;
        end else if (state_reg == S_IDLE) begin
          cmd_next   = ctrl_wdata.cmd;
          wcnt_next  = '0;
          state_next = S_COLLECT;
          if (is_stream(ctrl_wdata.mode)) begin
            st_next    = iv_reg ^ key_reg;
            rk_next    = key_reg;
            rc_next    = RCON_FIRST;
            rnd_next   = '0;
            state_next = S_CIPHER;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_IDLE;
      cmd_reg   <= CMD_ENC;
      mode_reg  <= '0;
      key_reg   <= '0;
      dkey_reg  <= '0;
      iv_reg    <= '0;
      buf_reg   <= '0;
      st_reg    <= '0;
      rk_reg    <= '0;
      rc_reg    <= RCON_FIRST;
      rnd_reg   <= '0;
      wcnt_reg  <= '0;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
      mode_reg  <= mode_next;
      key_reg   <= key_next;
      dkey_reg  <= dkey_next;
      iv_reg    <= iv_next;
      buf_reg   <= buf_next;
      st_reg    <= st_next;
      rk_reg    <= rk_next;
      rc_reg    <= rc_next;
      rnd_reg   <= rnd_next;
      wcnt_reg  <= wcnt_next;
      irq_reg   <= irq_next;
    end
  end

  // ==========================================================
  // output buffer; a full buffer stalls emit and part stages
  aes_fifo #(.W(AES_WORD_W), .D(FIFO_D)) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (output_request_trigger),
    .out_ready (out_ready),
    .out_data  (crypto_output_port)
  );

  assign block_done_irq           = irq_reg;
  assign crypto_ctrl_status = '{mode: mode_reg, ready: (state_reg == S_IDLE)};

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_enter_cipher;
    $rose(state_reg == S_CIPHER);
  endsequence
  sequence s_ten_rounds;
    ##9 (state_reg == S_CIPHER && rnd_reg == AES_LAST_R)
    ##1 (state_reg != S_CIPHER);
  endsequence

  // a key or iv load may cut a block short, so it cancels the count
  round_count_a: assert property (disable iff (!arst_n || (ctrl_wr
      && ctrl_wdata.start && ctrl_wdata.cmd inside {CMD_KEY, CMD_IV}))
      s_enter_cipher |-> s_ten_rounds)
    else $error("cipher did not take ten rounds");
  start_trig_a: assert property (state_reg == S_IDLE && ctrl_wr
      && ctrl_wdata.start && ctrl_wdata.cmd == CMD_ENC
      && ctrl_wdata.mode == MODE_ECB |=> input_request_trigger)
    else $error("start did not request input");
  load_abort_a: assert property (ctrl_wr && ctrl_wdata.start
      && ctrl_wdata.cmd == CMD_KEY |=> state_reg == S_COLLECT
      && wcnt_reg == 2'h0)
    else $error("key load did not abort");
  key_hold_a: assert property ($changed(key_reg) |->
      $past(state_reg == S_COLLECT && cmd_reg == CMD_KEY))
    else $error("key changed without key load");
  irq_pulse_a: assert property (block_done_irq |->
      crypto_ctrl_status.ready ##1 !block_done_irq)
    else $error("interrupt not a single pulse at idle");
  block_full_a: assert property (state_reg == S_COLLECT && in_valid
      && wcnt_reg == AES_LAST_W && cmd_reg == CMD_ENC
      |=> state_reg == S_CIPHER && rnd_reg == 4'h0)
    else $error("full block did not start cipher");
  part_pair_a: assert property (state_reg == S_PART && in_valid
      && input_request_trigger |-> f_in_valid
      && f_in_data == (crypto_input_port ^ ks))
    else $error("stream part did not yield output word");
  mac_quiet_a: assert property (state_reg == S_CIPHER && last
      && mode_reg == MODE_CBCMAC |=> !output_request_trigger
      || $past(output_request_trigger))
    else $error("mac chaining block produced output");

endmodule : aes_core
`default_nettype wire

// [aes_pkg.sv]
package aes_pkg;

  // ==========================================================
  // datapath geometry
  localparam int        AES_BLK_W   = 128;
  localparam int        AES_WORD_W  = 32;
  localparam int        AES_NR      = 10;
  localparam int        AES_FIFO_D  = 8;
  localparam logic [1:0] AES_LAST_W = 2'h3;
  localparam logic [3:0] AES_LAST_R = 4'h9;

  // ==========================================================
  // field arithmetic constants
  localparam logic [7:0] AES_POLY   = 8'h1B;
  localparam logic [7:0] RCON_FIRST = 8'h01;
  localparam logic [7:0] RCON_TOP   = 8'h80;
  localparam logic [7:0] RCON_LAST  = 8'h36;
  localparam logic [7:0] SBOX_C     = 8'h63;
  localparam logic [7:0] ISBOX_C    = 8'h05;
  localparam logic [31:0] MIX_ENC   = 32'h02030101;
  localparam logic [31:0] MIX_DEC   = 32'h0E0B0D09;

  // ==========================================================
  // control encodings
  typedef enum logic [2:0] {
    MODE_CBC    = 3'h0,
    MODE_CFB    = 3'h1,
    MODE_OFB    = 3'h2,
    MODE_CTR    = 3'h3,
    MODE_ECB    = 3'h4,
    MODE_CBCMAC = 3'h5
  } aes_mode_e;

  typedef enum logic [1:0] {
    CMD_ENC  = 2'h0,
    CMD_DEC  = 2'h1,
    CMD_KEY  = 2'h2,
    CMD_IV   = 2'h3
  } aes_cmd_e;

  typedef enum logic [2:0] {
    S_IDLE    = 3'h0,
    S_COLLECT = 3'h1,
    S_KEYEXP  = 3'h2,
    S_CIPHER  = 3'h3,
    S_PART    = 3'h4,
    S_EMIT    = 3'h5
  } aes_state_e;

  typedef struct packed {
    logic      start;
    aes_cmd_e  cmd;
    logic [2:0] mode;
  } aes_ctrl_s;

  typedef struct packed {
    logic [2:0] mode;
    logic       ready;
  } aes_stat_s;

endpackage : aes_pkg

// [aes_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module aes_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wp_reg, wp_next, rp_reg, rp_next;
  logic         push, pop;

  // ==========================================================
  // pointers carry one extra wrap bit so full and empty differ
  always_comb begin
    in_ready  = (wp_reg[AW-1:0] != rp_reg[AW-1:0])
                || (wp_reg[AW] == rp_reg[AW]);
    out_valid = (wp_reg != rp_reg);
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wp_next   = push ? wp_reg + 1'b1 : wp_reg;
    rp_next   = pop ? rp_reg + 1'b1 : rp_reg;
    out_data  = mem[rp_reg[AW-1:0]];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end

endmodule : aes_fifo
`default_nettype wire

// [aes_dma_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// host dma channels: one feeds the input port, one drains output
module aes_dma_model (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic        input_request_trigger,
  input  wire logic        output_request_trigger,
  input  wire logic [31:0] crypto_output_port,
  output var  logic [31:0] crypto_input_port,
  output var  logic        in_valid,
  output var  logic        out_ready
);
  logic [31:0] in_q[$];
  logic [31:0] out_q[$];

  initial begin
    crypto_input_port = 32'h0;
    in_valid          = 1'b0;
    out_ready         = 1'b1;
  end

  // ==========================================================
  // channel engines
  always @(posedge clk) begin
    if (in_valid && input_request_trigger) begin
      void'(in_q.pop_front());
    end
    if (out_ready && output_request_trigger) begin
      out_q.push_back(crypto_output_port);
    end
    #1;
    // words are queued whole by the bench, and a short block is not padded
    in_valid = (in_q.size() > 0);
    // an idle channel inverts the port each cycle, so the stale word returns every other cycle
    crypto_input_port = in_valid ? in_q[0] : ~crypto_input_port;
    out_ready = !stall;
  end
endmodule : aes_dma_model
`default_nettype wire

// [aes_core_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module aes_core_bench;
  import aes_pkg::*;
  localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
  localparam logic [127:0] PT  = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] CT  = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  localparam logic [127:0] CTZ = 128'h66E94BD4EF8A2C3B884CFA59CA342B2E;
  logic        clk;
  logic        arst_n;
  logic        ctrl_wr;
  logic        stall;
  aes_ctrl_s   ctrl_wdata;
  aes_stat_s   stat;
  logic [31:0] din;
  logic [31:0] dout;
  logic        in_valid;
  logic        in_req;
  logic        out_ready;
  logic        out_req;
  logic        irq;
  int          error_cnt;
  int          total_checks;
  logic [2:0]  sm [3] = '{3'h1, 3'h2, 3'h3};

  aes_core aes_core_i (
    .clk(clk), .arst_n(arst_n), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .crypto_ctrl_status(stat),
    .crypto_input_port(din), .in_valid(in_valid),
    .input_request_trigger(in_req), .crypto_output_port(dout),
    .out_ready(out_ready), .output_request_trigger(out_req),
    .block_done_irq(irq)
  );

  aes_dma_model aes_dma_model_i (
    .clk(clk), .stall(stall), .input_request_trigger(in_req),
    .output_request_trigger(out_req), .crypto_output_port(dout),
    .crypto_input_port(din), .in_valid(in_valid), .out_ready(out_ready)
  );

  // ==========================================================
  // clock, reset and checking helpers
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [127:0] got, exp, input string w);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk

  task automatic rst();
    arst_n = 1'b0;
    aes_dma_model_i.in_q.delete();
    aes_dma_model_i.out_q.delete();
    repeat (12) @(posedge clk);
    #1;
    arst_n = 1'b1;
  endtask : rst

  // ==========================================================
  // host access: control writes and dma block traffic
  task automatic cmd(input aes_cmd_e c, input logic [2:0] m);
    @(posedge clk);
    #1;
    ctrl_wr    = 1'b1;
    ctrl_wdata = '{1'b1, c, m};
    @(posedge clk);
    #1;
    ctrl_wr = 1'b0;
  endtask : cmd

  task automatic feed(input logic [127:0] d, input int n);
    for (int i = 3; i > 3 - n; i--) aes_dma_model_i.in_q.push_back(d[32*i+:32]);
  endtask : feed

  task automatic wait_irq(input int n);
    int i;
    i = 0;
    while (irq !== 1'b1 && i < n) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk({irq, stat.ready}, 2'b11, "irq");
  endtask : wait_irq

  task automatic get(output logic [127:0] b);
    int i;
    i = 0;
    while (aes_dma_model_i.out_q.size() < 4 && i < 100) begin
      @(posedge clk);
      #1;
      i++;
    end
    b = 'x;
    if (aes_dma_model_i.out_q.size() >= 4) begin
      for (i = 3; i >= 0; i--) b[32*i+:32] = aes_dma_model_i.out_q.pop_front();
    end
  endtask : get

  task automatic blk(input aes_cmd_e c, input logic [2:0] m,
                     input logic [127:0] d, e, input logic o);
    logic [127:0] r;
    logic         q;
    // stream modes run the cipher before asking for the first part
    q = (c == CMD_KEY) || (c == CMD_IV) || !(m inside {3'h1, 3'h2, 3'h3});
    feed(d, 4);
    cmd(c, m);
    chk({stat, in_req}, {m, 1'b0, q}, "start");
    wait_irq(80);
    if (o) begin
      get(r);
      chk(r, e, "data");
    end
  endtask : blk

  // auth block zero: flag byte, then nonce, then length
  function automatic logic [127:0] ccm_b0(input logic [7:0]   f,
                                          input logic [103:0] nc,
                                          input logic [15:0]  ln);
    return {f, nc, ln};
  endfunction : ccm_b0

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  initial begin
    #300000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  // ==========================================================
  // test sequence
  initial begin
    logic [127:0] r;
    int           n;
    error_cnt    = 0;
    total_checks = 0;
    ctrl_wr      = 1'b0;
    ctrl_wdata   = '0;
    stall        = 1'b0;
    rst();
    chk({stat, in_req, out_req, irq}, 7'h08, "reset");
    blk(CMD_ENC, 3'h4, '0, CTZ, 1'b1);
    blk(CMD_KEY, 3'h4, KEY, '0, 1'b0);
    blk(CMD_ENC, 3'h0, PT, CT, 1'b1);
    blk(CMD_ENC, 3'h0, PT ^ CT, CT, 1'b1);
    blk(CMD_ENC, 3'h4, PT, CT, 1'b1);
    blk(CMD_DEC, 3'h4, CT, PT, 1'b1);
    blk(CMD_IV, 3'h0, '0, '0, 1'b0);
    blk(CMD_DEC, 3'h0, CT, PT, 1'b1);
    blk(CMD_DEC, 3'h0, CT, PT ^ CT, 1'b1);
    $display("test block modes done");
    blk(CMD_IV, 3'h5, '0, '0, 1'b0);
    blk(CMD_ENC, 3'h5, ccm_b0(PT[127:120], PT[119:16], PT[15:0]), '0,
        1'b0);
    chk(aes_dma_model_i.out_q.size(), 0, "mac quiet");
    blk(CMD_ENC, 3'h0, PT ^ CT, CT, 1'b1);
    $display("test mac done");
    foreach (sm[i]) begin
      blk(CMD_IV, sm[i], PT, '0, 1'b0);
      blk(CMD_ENC, sm[i], '0, CT, 1'b1);
    end
    blk(CMD_IV, 3'h1, PT, '0, 1'b0);
    blk(CMD_DEC, 3'h1, CT, '0, 1'b1);
    $display("test stream modes done");
    feed(PT, 2);
    cmd(CMD_ENC, 3'h4);
    n = 0;
    while (aes_dma_model_i.in_q.size() > 0 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    // the load starts before its words queue, as the trigger is still up
    cmd(CMD_IV, 3'h4);
    chk({stat, in_req}, {3'h4, 1'b0, 1'b1}, "abort start");
    feed('0, 4);
    wait_irq(80);
    chk(aes_dma_model_i.out_q.size(), 0, "abort quiet");
    blk(CMD_ENC, 3'h4, PT, CT, 1'b1);
    $display("test abort done");
    // a stalled sink lets the output fifo fill with two blocks and stall the third in emit
    stall = 1'b1;
    blk(CMD_ENC, 3'h4, PT, CT, 1'b0);
    blk(CMD_ENC, 3'h4, PT, CT, 1'b0);
    feed(PT, 4);
    cmd(CMD_ENC, 3'h4);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      n += int'(irq);
    end
    chk({n[7:0], out_req, stat.ready}, 10'h2, "full");
    cmd(CMD_ENC, 3'h4);
    stall = 1'b0;
    wait_irq(80);
    repeat (3) begin
      get(r);
      chk(r, CT, "drain");
    end
    repeat (4) @(posedge clk);
    #1;
    chk({out_req, stat.ready}, 2'b01, "drained");
    $display("test fifo done");
    rst();
    chk({stat, in_req, out_req, irq}, 7'h08, "reset again");
    blk(CMD_KEY, 3'h4, KEY, '0, 1'b0);
    blk(CMD_ENC, 3'h0, PT, CT, 1'b1);
    $display("test second reset done");
    results();
  end
endmodule : aes_core_bench
`default_nettype wire
